//--- pc_fast_stack_qclock.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Shadow stack one deep for three registers
// - Interrupt entry copies context into hidden shadow
// - Fast return reloads context from shadow
// - Both interrupt priorities save alike
// - Nested high entry overwrites earlier shadow
// - Fast call saves context for fast return
// - Counter 21 bits; low byte read/write
// - Middle byte only via high holding latch
// - Upper byte only via upper holding latch
// - Counter bit zero always held at zero
// - Sequential fetch advances counter by two
// - Calls, jumps, branches load counter directly
// - Low byte write pulls both latches in
// - Low byte read copies upper bytes out
// - Oscillator divided by four into phases
// - Increment in phase one, latch word phase four
// - Execute latched word during next cycle
module pc_fast_stack_qclock
    import pfsq_pkg::*;
#(
    parameter int PC_W = PFSQ_PC_W,
    parameter int IW_W = PFSQ_IW_W
)
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire pfsq_ctl_s        ctl,
    input  wire pfsq_ctx_s        ctx_cur,
    input  wire logic [IW_W-1:0]  prog_data,
    output var  logic [PC_W-1:0]  prog_addr,
    output var  logic [IW_W-1:0]  exec_word,
    output var  logic             exec_start,
    output var  logic [7:0]       pc_low_byte,
    output var  logic [7:0]       pcl_rd_data,
    output var  logic [7:0]       pc_high_holding_latch,
    output var  logic [4:0]       pc_upper_holding_latch,
    output var  logic             phase_one,
    output var  logic             phase_two,
    output var  logic             phase_three,
    output var  logic             phase_four,
    output var  logic             ctx_restore_valid,
    output var  pfsq_ctx_s        ctx_restored
);

    // ************************************************************
    // Phase generator
    // ************************************************************
    // Every state change below is keyed to one phase edge, so a
    // request held longer than a cycle still acts only once per
    // instruction cycle.
    logic ph1;
    logic ph2;
    logic ph3;
    logic ph4;

    pfsq_phase_gen u_phase
    (
        .clk         (clk),
        .arst_n      (arst_n),
        .phase_one   (ph1),
        .phase_two   (ph2),
        .phase_three (ph3),
        .phase_four  (ph4)
    );

    assign phase_one   = ph1;
    assign phase_two   = ph2;
    assign phase_three = ph3;
    assign phase_four  = ph4;

    // ************************************************************
    // Request qualification
    // ************************************************************
    // Core requests act only on the phase_four edge, which closes
    // the execute cycle; elsewhere they are ignored.
    // Requests are levels; the core need not pulse them.
    logic take_int;
    logic take_fcall;
    logic take_fret;
    logic take_load;
    logic take_pcl_wr;
    logic take_pcl_rd;
    logic take_lath_wr;
    logic take_latu_wr;
    logic shadow_save;

    assign take_int     = ph4 & ctl.int_vector;
    assign take_fcall   = ph4 & ctl.fast_call;
    assign take_fret    = ph4 & ctl.fast_return;
    assign take_load    = ph4 & ctl.pc_load;
    assign take_pcl_wr  = ph4 & ctl.pcl_wr;
    assign take_pcl_rd  = ph4 & ctl.pcl_rd;
    assign take_lath_wr = ph4 & ctl.lath_wr;
    assign take_latu_wr = ph4 & ctl.latu_wr;

    // Save sources kept apart so each can be traced on its own;
    // priority of the interrupt is not looked at.
    logic save_on_int;
    logic save_on_call;

    assign save_on_int  = take_int;
    assign save_on_call = take_fcall;
    assign shadow_save  = save_on_int | save_on_call;

    // ************************************************************
    // Shadow stack
    // ************************************************************
    // A fast return in the same edge as a save reads the old copy;
    // the save still lands.
    // Restore only reads the copy, so it never disturbs a save.
    pfsq_shadow u_shadow
    (
        .clk           (clk),
        .arst_n        (arst_n),
        .save          (shadow_save),
        .restore       (take_fret),
        .ctx_in        (ctx_cur),
        .restore_valid (ctx_restore_valid),
        .ctx_out       (ctx_restored)
    );

    // ************************************************************
    // Program counter
    // ************************************************************
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_target_al;
    logic [PC_W-1:0] pc_from_pcl;
    logic            pc_any_wr;

    // The step wraps silently at the top of the address space.
    // Sequential step is two bytes per instruction word
    assign pc_inc = pc_r + PC_W'(PFSQ_PC_STEP);

    // Direct load for call, jump, branch, return, vector
    assign pc_target_al = {ctl.pc_target[PC_W-1:1], PFSQ_PCL_LSB_V};

    // Low byte write merges both latches into the upper bytes
    assign pc_from_pcl = {pc_upper_holding_latch,
                          pc_high_holding_latch,
                          ctl.pcl_wr_data[7:1],
                          PFSQ_PCL_LSB_V};

    assign pc_any_wr = take_int | take_load | take_pcl_wr;

    // ************************************************************
    // Next counter selection
    // ************************************************************
    // One select per source, highest first, so two writes in one
    // edge can never blend into a mixed address.
    logic sel_direct;
    logic sel_pcl;
    logic sel_step;

    assign sel_direct = take_int | take_load;
    assign sel_pcl    = take_pcl_wr & ~sel_direct;
    assign sel_step   = ph1 & ~sel_direct & ~sel_pcl;

    // Direct load outranks a low byte write in the same edge
    always_comb
    begin
        pc_nxt = pc_r;
        if (sel_direct)
            pc_nxt = pc_target_al;
        else if (sel_pcl)
            pc_nxt = pc_from_pcl;
        else if (sel_step)
            pc_nxt = pc_inc;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pc_r <= PFSQ_PC_RST;
        else
            pc_r <= pc_nxt;
    end

    // ************************************************************
    // Fetch address
    // ************************************************************
    logic fetch_cap;

    // Counter writes never fall on phase_one now; the guard keeps a
    // write from ever presenting a half-updated fetch address.
    assign fetch_cap = ph1 & ~pc_any_wr;

    // Captured at phase_one before the step, so the word fetched
    // this cycle is the one the counter pointed at.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prog_addr <= PFSQ_PC_RST;
        else if (fetch_cap)
            prog_addr <= pc_r;
    end

    // Low byte mirror, readable at all times
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pc_low_byte <= PFSQ_BYTE_RST;
        else
            pc_low_byte <= pc_nxt[7:0];
    end

    // ************************************************************
    // Holding latches
    // ************************************************************
    // A low byte read snapshots the upper bytes; it wins over a
    // direct latch write in the same edge so the pair stays coherent.
    logic [7:0] lath_nxt;
    logic [4:0] latu_nxt;
    logic [7:0] pc_mid;
    logic [4:0] pc_up;
    logic       lat_snap;
    logic       lath_load;
    logic       latu_load;

    // Upper bytes of the counter, never exposed except via a read
    assign pc_mid = pc_r[15:8];
    assign pc_up  = pc_r[20:16];

    // A snapshot blocks both direct latch writes
    assign lat_snap  = take_pcl_rd;
    assign lath_load = take_lath_wr & ~take_pcl_rd;
    assign latu_load = take_latu_wr & ~take_pcl_rd;

    always_comb
    begin
        lath_nxt = pc_high_holding_latch;
        latu_nxt = pc_upper_holding_latch;
        if (lat_snap)
        begin
            lath_nxt = pc_mid;
            latu_nxt = pc_up;
        end
        if (lath_load)
            lath_nxt = ctl.lath_wr_data;
        if (latu_load)
            latu_nxt = ctl.latu_wr_data;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_high_holding_latch  <= PFSQ_LATH_RST;
            pc_upper_holding_latch <= PFSQ_LATU_RST;
        end
        else
        begin
            pc_high_holding_latch  <= lath_nxt;
            pc_upper_holding_latch <= latu_nxt;
        end
    end

    // Read data for the low byte, held until the next read
    // Held so a slow core may pick it up any time later.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pcl_rd_data <= PFSQ_BYTE_RST;
        else if (take_pcl_rd)
            pcl_rd_data <= pc_r[7:0];
    end

    // ************************************************************
    // Instruction register and execute stage
    // ************************************************************
    logic [IW_W-1:0] ir_r;

    // Fetched word is caught at the phase_four edge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ir_r <= PFSQ_IR_RST;
        else if (ph4)
            ir_r <= prog_data;
    end

    // Word moves to execute at phase_one and stays four phases,
    // overlapping the next fetch. A flow change does not flush it:
    // the core squashes the stale word itself.
    assign exec_word = ir_r;

    // Start strobe marks the first phase of each execute cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            exec_start <= 1'b0;
        else
            exec_start <= ph4;
    end

endmodule

`default_nettype wire

//--- pc_fast_stack_qclock_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end

module pc_fast_stack_qclock_tb_top
    import pfsq_pkg::*;
;
    logic        clk, arst_n, exec_start, ctx_restore_valid;
    logic        phase_one, phase_two, phase_three, phase_four;
    pfsq_ctl_s   ctl;
    pfsq_ctx_s   ctx_cur, ctx_restored, sh_m, rs_m;
    logic [15:0] prog_data, exec_word;
    logic [20:0] prog_addr, pc_m, fa_m;
    logic [7:0]  pc_low_byte, pcl_rd_data, pc_high_holding_latch, lh_m, rd_m;
    logic [4:0]  pc_upper_holding_latch, lu_m;
    int          bad_count = 0;
    int          compares = 0;
    logic [7:0]  corner [13] = '{8'h00, 8'h00, 8'h03, 8'h08, 8'h13, 8'h07, 8'h18, 8'h80,
                                 8'h80, 8'h20, 8'h50, 8'hE0, 8'h20};

    pc_fast_stack_qclock pc_fast_stack_qclock_inst (.clk, .arst_n, .ctl, .ctx_cur, .prog_data,
        .prog_addr, .exec_word, .exec_start, .pc_low_byte, .pcl_rd_data, .pc_high_holding_latch,
        .pc_upper_holding_latch, .phase_one, .phase_two, .phase_three, .phase_four,
        .ctx_restore_valid, .ctx_restored);
    pfsq_prog_mem pfsq_prog_mem_inst (.clk, .arst_n, .phase_three, .prog_addr, .prog_data);

    // Free-running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic pfsq_ctl_s req(input logic [7:0] f);
        logic [63:0] r;
        r = {$urandom, $urandom};
        req = r[49:0];
        {req.int_vector, req.fast_call, req.fast_return, req.pc_load, req.pcl_wr, req.pcl_rd,
            req.lath_wr, req.latu_wr} = f;
    endfunction

    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reset held six cycles; model restarts at the first fetch
    task automatic do_reset;
        arst_n = 1'b0;
        repeat (6) @(negedge clk);
        `CHK("reset_addr", 21'h0, prog_addr)
        `CHK("reset_latches", 13'h0, {pc_upper_holding_latch, pc_high_holding_latch})
        `CHK("reset_phase", 1'b1, phase_one)
        arst_n = 1'b1;
        {pc_m, fa_m, lh_m, lu_m, rd_m, sh_m, rs_m} = {21'h2, 21'h0, 13'h0, 8'h0, 48'h0};
    endtask

    // One instruction cycle; junk requests outside phase four must be ignored
    task automatic cyc(input pfsq_ctl_s c);
        logic [20:0] np;
        while (!phase_four)
        begin
            ctl = req(8'($urandom));
            ctx_cur = 24'($urandom);
            @(negedge clk);
        end
        ctl = c;
        ctx_cur = 24'($urandom);
        np = pc_m;
        if (c.int_vector || c.pc_load)
            np = c.pc_target & 21'h1FFFFE;
        else if (c.pcl_wr)
            np = {lu_m, lh_m, c.pcl_wr_data & 8'hFE};
        if (c.pcl_rd)
            {lu_m, lh_m, rd_m} = pc_m;
        else
        begin
            if (c.lath_wr) lh_m = c.lath_wr_data;
            if (c.latu_wr) lu_m = c.latu_wr_data;
        end
        if (c.fast_return) rs_m = sh_m;
        if (c.int_vector || c.fast_call) sh_m = ctx_cur; // Own copy, as software
        @(negedge clk);
        ctl = req(8'($urandom));
        ctx_cur = 24'($urandom);
        `CHK("exec_start", 1'b1, exec_start)
        `CHK("phases", 4'h1, {phase_four, phase_three, phase_two, phase_one})
        `CHK("exec_word", fa_m[16:1] ^ 16'h5A3C, exec_word)
        `CHK("high_latch", lh_m, pc_high_holding_latch)
        `CHK("upper_latch", lu_m, pc_upper_holding_latch)
        `CHK("pcl_rd_data", rd_m, pcl_rd_data)
        `CHK("restore_valid", c.fast_return, ctx_restore_valid)
        `CHK("ctx_restored", rs_m, ctx_restored)
        @(negedge clk);
        `CHK("prog_addr", np, prog_addr)
        `CHK("pc_low_byte", 8'(np + 21'h2), pc_low_byte)
        `CHK("exec_start_off", 1'b0, exec_start)
        `CHK("restore_off", 1'b0, ctx_restore_valid)
        fa_m = np;
        pc_m = np + 21'h2;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        arst_n = 1'b0;
        ctl = '0;
        ctx_cur = '0;
        void'($urandom(89));
        do_reset();
        $display("test reset done");
        foreach (corner[i]) cyc(req(corner[i]));
        $display("test corners done");
        repeat (200) cyc(req(8'($urandom & $urandom)));
        $display("test random done");
        do_reset();
        foreach (corner[i]) cyc(req(corner[i]));
        $display("test second reset done");
        print_verdict();
    end

    // Watchdog far beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule

`default_nettype wire

//--- pfsq_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none

module pfsq_phase_gen
    import pfsq_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  arst_n,
    output var  logic  phase_one,
    output var  logic  phase_two,
    output var  logic  phase_three,
    output var  logic  phase_four
);

    // ************************************************************
    // Divide by four
    // ************************************************************
    pfsq_phase_e ph_r;
    pfsq_phase_e ph_nxt;

    // Ring of four, one phase per rising oscillator edge
    always_comb
    begin
        case (ph_r)
            PFSQ_PH_ONE:   ph_nxt = PFSQ_PH_TWO;
            PFSQ_PH_TWO:   ph_nxt = PFSQ_PH_THREE;
            PFSQ_PH_THREE: ph_nxt = PFSQ_PH_FOUR;
            PFSQ_PH_FOUR:  ph_nxt = PFSQ_PH_ONE;
            default:       ph_nxt = PFSQ_PH_ONE; // Recover from bad code
        endcase
    end

    // Starts in phase_one after reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ph_r <= PFSQ_PH_ONE;
        else
            ph_r <= ph_nxt;
    end

    // Non-overlapping strobes straight from the state flops
    assign phase_one   = ph_r[0];
    assign phase_two   = ph_r[1];
    assign phase_three = ph_r[2];
    assign phase_four  = ph_r[3];

endmodule

`default_nettype wire

//--- pfsq_pkg.sv
`default_nettype none

package pfsq_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PFSQ_PC_W   = 21;
    localparam int PFSQ_IW_W   = 16;
    localparam int PFSQ_BYTE_W = 8;
    localparam int PFSQ_UP_W   = 5;

    // ************************************************************
    // Reset values and steps
    // ************************************************************
    localparam logic [20:0] PFSQ_PC_RST     = 21'h000000;
    localparam logic [20:0] PFSQ_PC_STEP    = 21'h000002;
    localparam logic [7:0]  PFSQ_LATH_RST   = 8'h00;
    localparam logic [4:0]  PFSQ_LATU_RST   = 5'h00;
    localparam logic [15:0] PFSQ_IR_RST     = 16'h0000;
    localparam logic [7:0]  PFSQ_BYTE_RST   = 8'h00;
    localparam int          PFSQ_PCL_LSB    = 0;
    localparam logic        PFSQ_PCL_LSB_V  = 1'b0;

    // ************************************************************
    // Phase generator, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        PFSQ_PH_ONE   = 4'h1,
        PFSQ_PH_TWO   = 4'h2,
        PFSQ_PH_THREE = 4'h4,
        PFSQ_PH_FOUR  = 4'h8
    } pfsq_phase_e;

    // ************************************************************
    // Carriers
    // ************************************************************
    // Saved context: status, working and bank select
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working_register;
        logic [7:0] bank_select_register;
    } pfsq_ctx_s;

    // Core requests, sampled in phase_four
    typedef struct packed {
        logic        int_vector;
        logic        fast_call;
        logic        fast_return;
        logic        pc_load;
        logic [20:0] pc_target;
        logic        pcl_wr;
        logic [7:0]  pcl_wr_data;
        logic        pcl_rd;
        logic        lath_wr;
        logic [7:0]  lath_wr_data;
        logic        latu_wr;
        logic [4:0]  latu_wr_data;
    } pfsq_ctl_s;

    localparam pfsq_ctx_s PFSQ_CTX_RST = '0;

endpackage

`default_nettype wire

//--- pfsq_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none

module pfsq_prog_mem
    import pfsq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        phase_three,
    input  wire logic [20:0] prog_addr,
    output var  logic [15:0] prog_data
);
    // Word valid only in the phase four cycle; toggles otherwise so stale data shows
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prog_data <= 16'hFFFF;
        else if (phase_three)
            prog_data <= prog_addr[16:1] ^ 16'h5A3C;
        else
            prog_data <= ~prog_data;
    end
endmodule

`default_nettype wire

//--- pfsq_properties.sv
`timescale 1ns/100ps
`default_nettype none

module pfsq_checker
    import pfsq_pkg::*;
#(
    parameter int PC_W = PFSQ_PC_W,
    parameter int IW_W = PFSQ_IW_W
)
(
    input wire logic            clk,
    input wire logic            arst_n,
    input wire pfsq_ctl_s       ctl,
    input wire pfsq_ctx_s       ctx_cur,
    input wire logic [IW_W-1:0] prog_data,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [IW_W-1:0] exec_word,
    input wire logic            exec_start,
    input wire logic [7:0]      pc_low_byte,
    input wire logic [7:0]      pcl_rd_data,
    input wire logic [7:0]      pc_high_holding_latch,
    input wire logic [4:0]      pc_upper_holding_latch,
    input wire logic            phase_one,
    input wire logic            phase_two,
    input wire logic            phase_three,
    input wire logic            phase_four,
    input wire logic            ctx_restore_valid,
    input wire pfsq_ctx_s       ctx_restored
);
    // ************************************************************
    // Helper logic
    // ************************************************************
    // Own copy of the hidden shadow, since it has no port
    pfsq_ctx_s shadow_r;
    logic      direct_ld;
    assign direct_ld = phase_four && (ctl.pc_load || ctl.int_vector);

    // Save on interrupt entry or fast call
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            shadow_r <= PFSQ_CTX_RST;
        else if (phase_four && (ctl.int_vector || ctl.fast_call))
            shadow_r <= ctx_cur;
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_walk;
        phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
    endsequence
    property p_phase_walk; phase_one |=> s_walk; endproperty
    a_phase_walk: assert property (p_phase_walk)
        else $error("phase order broken");
    property p_onehot; $onehot({phase_one, phase_two, phase_three, phase_four}); endproperty
    a_onehot: assert property (p_onehot)
        else $error("phases not one-hot");
    property p_reset_state;
        $rose(arst_n) |-> phase_one && prog_addr == '0
            && pc_high_holding_latch == 8'h00 && pc_upper_holding_latch == 5'h00;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("bad state after reset");
    property p_seq_step;
        phase_four && !direct_ld && !ctl.pcl_wr |=> ##1 prog_addr == $past(prog_addr, 2) + 21'h2;
    endproperty
    a_seq_step: assert property (p_seq_step)
        else $error("fetch address did not step by two");
    property p_direct_load;
        direct_ld |=> ##1 prog_addr == ($past(ctl.pc_target, 2) & 21'h1FFFFE);
    endproperty
    a_direct_load: assert property (p_direct_load)
        else $error("direct load wrong");
    property p_low_write;
        phase_four && ctl.pcl_wr && !direct_ld |=> ##1 prog_addr == {$past(pc_upper_holding_latch,
            2), $past(pc_high_holding_latch, 2), $past(ctl.pcl_wr_data, 2) & 8'hFE};
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low byte write did not pull latches");
    property p_low_read;
        phase_four && ctl.pcl_rd |=> {pc_upper_holding_latch, pc_high_holding_latch,
            pcl_rd_data} == $past(prog_addr) + 21'h2;
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low byte read did not copy upper bytes");
    property p_lath_write;
        phase_four && ctl.lath_wr && !ctl.pcl_rd |=> pc_high_holding_latch == $past(ctl.lath_wr_data);
    endproperty
    a_lath_write: assert property (p_lath_write)
        else $error("high latch write lost");
    property p_latu_write;
        phase_four && ctl.latu_wr && !ctl.pcl_rd |=> pc_upper_holding_latch == $past(ctl.latu_wr_data);
    endproperty
    a_latu_write: assert property (p_latu_write)
        else $error("upper latch write lost");
    property p_low_mirror; phase_three |-> pc_low_byte == prog_addr[7:0] + 8'h02; endproperty
    a_low_mirror: assert property (p_low_mirror)
        else $error("low byte does not follow counter");
    property p_fetch; phase_four |=> exec_start && exec_word == $past(prog_data); endproperty
    a_fetch: assert property (p_fetch)
        else $error("word not latched in phase four");
    property p_exec_pulse; exec_start |-> phase_one; endproperty
    a_exec_pulse: assert property (p_exec_pulse)
        else $error("execute start outside phase one");
    property p_restore;
        phase_four && ctl.fast_return |=> ctx_restore_valid && ctx_restored == $past(shadow_r);
    endproperty
    a_restore: assert property (p_restore)
        else $error("restored context wrong");
    property p_restore_only; !(phase_four && ctl.fast_return) |=> !ctx_restore_valid; endproperty
    a_restore_only: assert property (p_restore_only)
        else $error("spurious restore");
endmodule

bind pc_fast_stack_qclock pfsq_checker #(.PC_W(PC_W), .IW_W(IW_W)) pfsq_checker_inst (.clk,
    .arst_n, .ctl, .ctx_cur, .prog_data, .prog_addr, .exec_word, .exec_start, .pc_low_byte,
    .pcl_rd_data, .pc_high_holding_latch, .pc_upper_holding_latch, .phase_one, .phase_two,
    .phase_three, .phase_four, .ctx_restore_valid, .ctx_restored);

`default_nettype wire

//--- pfsq_shadow.sv
`timescale 1ns/100ps
`default_nettype none

module pfsq_shadow
    import pfsq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       save,
    input  wire logic       restore,
    input  wire pfsq_ctx_s  ctx_in,
    output var  logic       restore_valid,
    output var  pfsq_ctx_s  ctx_out
);

    // ************************************************************
    // One-deep shadow copy
    // ************************************************************
    // No software port: the copy is only reachable via save/restore
    pfsq_ctx_s shadow_r;

    // Any save simply overwrites, nothing older is kept
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            shadow_r <= PFSQ_CTX_RST;
        else if (save)
            shadow_r <= ctx_in;
    end

    // Restore answer, registered so the core sees a clean pulse
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            restore_valid <= 1'b0;
            ctx_out       <= PFSQ_CTX_RST;
        end
        else
        begin
            restore_valid <= restore;
            if (restore)
                ctx_out <= shadow_r;
        end
    end

endmodule

`default_nettype wire
